// ---- shared/tmwo_defs.svh ----
`ifndef TMWO_DEFS_SVH
`define TMWO_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define TMWO_ADDR_W 16
`define TMWO_DATA_W 16
`define TMWO_OFS_PERIOD 16'h5202
`define TMWO_OFS_COMPARE 16'h5204
`define TMWO_OFS_CTRL 16'h521e
`define TMWO_OFS_EVT_EN 16'h5230
`define TMWO_OFS_EVT_FLAGS 16'h5238

// ****************************************
// control field positions
// ****************************************
`define TMWO_CTL_POLARITY 0
`define TMWO_CTL_IDLE_SEL 1
`define TMWO_CTL_OUT_EN 2
`define TMWO_CTL_FILT_SEL 4
`define TMWO_CTL_PIN_LVL 5
`define TMWO_CTL_ADC_LIM 6

// ****************************************
// event bit positions (enable and flags)
// ****************************************
`define TMWO_EVT_PIN 0
`define TMWO_EVT_ADC 1
`define TMWO_EVT_PRD 2
`define TMWO_EVT_CMP 3
`define TMWO_EVT_W 4

// ****************************************
// reset values
// ****************************************
`define TMWO_RST_VALUE 16'h0000
`define TMWO_RST_CTRL 7'h00
`define TMWO_RST_EVT 4'h0

// ****************************************
// noise filter lengths in system clocks
// ****************************************
`define TMWO_FILT_SHORT 6
`define TMWO_FILT_LONG 12

`endif

// ---- shared/tmwo_pkg.sv ----
package tmwo_pkg;

  // ****************************************
  // control register fields
  // ****************************************
  typedef struct packed {
    logic adc_protect_limit_sel;
    logic pin_protect_level_sel;
    logic protect_filter_length_sel;
    logic reserved3;
    logic wave_out_enable;
    logic idle_level_sel;
    logic polarity_invert;
  } tmwo_ctrl_t;

  // ****************************************
  // event causes, one bit each
  // ****************************************
  typedef struct packed {
    logic compare_event;
    logic period_event;
    logic adc_protect;
    logic pin_protect;
  } tmwo_evt_t;

  // ****************************************
  // waveform generator states
  // ****************************************
  typedef enum logic [1:0] {
    TMWO_ST_IDLE = 2'b00,
    TMWO_ST_OFF = 2'b01,
    TMWO_ST_ON = 2'b10
  } tmwo_state_t;

endpackage

// ---- logic/tmwo_noise_filter.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "tmwo_defs.svh"

module tmwo_noise_filter #(
  parameter int SHORT_LEN = `TMWO_FILT_SHORT,
  parameter int LONG_LEN = `TMWO_FILT_LONG,
  parameter int CNT_W = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_raw,
  input wire logic i_long_sel,
  output logic o_level
);

  logic [CNT_W-1:0] stable_cnt_q;
  logic [CNT_W-1:0] limit;
  logic level_q;

  // accept a change only after the full run of differing samples
  assign limit = i_long_sel ? CNT_W'(LONG_LEN - 1) : CNT_W'(SHORT_LEN - 1);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      stable_cnt_q <= '0;
    end else if (i_raw == level_q) begin
      stable_cnt_q <= '0;
    end else if (stable_cnt_q == limit) begin
      stable_cnt_q <= '0;
    end else begin
      stable_cnt_q <= stable_cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      level_q <= 1'b0;
    end else if (i_raw != level_q && stable_cnt_q == limit) begin
      level_q <= i_raw;
    end
  end

  assign o_level = level_q;

endmodule
`default_nettype wire

// ---- logic/tmwo_top.sv ----
// Behaviour
// - idle level bit selects level held while output off; 0 low, 1 high.
// - polarity bit 1 gives active-low waveform instead of active-high.
// - effective idle level is idle level bit XOR polarity bit.
// - idle level driven until a counter event changes it after enable.
// - enable 1 starts waveform; 0 stops and returns output to idle level.
// - active-high: output rises one step after compare, compare event raised.
// - active-high: period match resets counter, output low, period event.
// - active-low: output starts high, falls after compare, rises on period.
// - second output is complement of primary waveform output.
// - enabled protection trip forces outputs to idle state and raises event.
// - adc protection enable arms trip from converter channel 0 out-of-range.
// - limit select 0 trips on result below lower limit.
// - out-of-range sets adc flag; forces outputs only when enabled.
// - pin protection enable arms trip from protection input pin.
// - level select 1 trips on low pin, 0 on high; sets pin flag.
// - pin filter rejects pulses under 12 clocks (select 1) or 6 (select 0).
// - compare above period gives no compare event; output stays off.
// - four causes share one request line; flags tell the cause.
// - flags cleared by writing 1; request held while enabled flag set.
// - compare/period flags need enables; protection flags set regardless.
`timescale 1ns/1ns
`default_nettype none
`include "tmwo_defs.svh"

module tmwo_top #(
  parameter int VALUE_W = `TMWO_DATA_W
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  // register port
  input wire logic [`TMWO_ADDR_W-1:0] i_reg_addr,
  input wire logic [`TMWO_DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  output logic [`TMWO_DATA_W-1:0] o_reg_rdata,
  // counter side
  input wire logic [VALUE_W-1:0] i_count_value,
  input wire logic i_count_tick,
  output logic o_compare_match,
  output logic o_period_match,
  // protection sources
  input wire logic i_adc_upper_out_of_range,
  input wire logic i_adc_lower_out_of_range,
  input wire logic i_protect_input_pin,
  // outputs to gate drivers and interrupt controller
  output logic o_wave_out,
  output logic o_wave_out_n,
  output logic o_irq
);

  // ****************************************
  // declarations
  // ****************************************
  logic [VALUE_W-1:0] period_value_q;
  logic [VALUE_W-1:0] compare_value_q;
  tmwo_pkg::tmwo_ctrl_t ctrl_q;
  tmwo_pkg::tmwo_evt_t enable_q;
  tmwo_pkg::tmwo_evt_t flags_q;
  tmwo_pkg::tmwo_evt_t flags_d;
  tmwo_pkg::tmwo_evt_t set_evt;
  tmwo_pkg::tmwo_evt_t clr_evt;
  tmwo_pkg::tmwo_state_t state_q;
  tmwo_pkg::tmwo_state_t state_d;
  logic [`TMWO_DATA_W-1:0] rdata_q;
  logic wave_q;
  logic wave_d;
  logic idle_level;
  logic hit_period;
  logic hit_compare;
  logic pin_filtered;
  logic adc_trip;
  logic pin_trip;
  logic force_idle;
  logic wr_period;
  logic wr_compare;
  logic wr_ctrl;
  logic wr_enable;
  logic wr_flags;

  // ****************************************
  // address decode
  // ****************************************
  assign wr_period = i_reg_write && (i_reg_addr == `TMWO_OFS_PERIOD);
  assign wr_compare = i_reg_write && (i_reg_addr == `TMWO_OFS_COMPARE);
  assign wr_ctrl = i_reg_write && (i_reg_addr == `TMWO_OFS_CTRL);
  assign wr_enable = i_reg_write && (i_reg_addr == `TMWO_OFS_EVT_EN);
  assign wr_flags = i_reg_write && (i_reg_addr == `TMWO_OFS_EVT_FLAGS);

  // ****************************************
  // data registers
  // ****************************************
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      period_value_q <= VALUE_W'(`TMWO_RST_VALUE);
    end else if (wr_period) begin
      period_value_q <= i_reg_wdata[VALUE_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      compare_value_q <= VALUE_W'(`TMWO_RST_VALUE);
    end else if (wr_compare) begin
      compare_value_q <= i_reg_wdata[VALUE_W-1:0];
    end
  end

  // ****************************************
  // control register
  // ****************************************
  // an enabled trip drops the output enable; the trip wins over a write
  // so software cannot restart into a live fault in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl_q <= `TMWO_RST_CTRL;
    end else begin
      if (wr_ctrl) begin
        ctrl_q.polarity_invert <= i_reg_wdata[`TMWO_CTL_POLARITY];
        ctrl_q.idle_level_sel <= i_reg_wdata[`TMWO_CTL_IDLE_SEL];
        ctrl_q.wave_out_enable <= i_reg_wdata[`TMWO_CTL_OUT_EN];
        ctrl_q.protect_filter_length_sel <= i_reg_wdata[`TMWO_CTL_FILT_SEL];
        ctrl_q.pin_protect_level_sel <= i_reg_wdata[`TMWO_CTL_PIN_LVL];
        ctrl_q.adc_protect_limit_sel <= i_reg_wdata[`TMWO_CTL_ADC_LIM];
      end
      if (force_idle) begin
        ctrl_q.wave_out_enable <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      enable_q <= `TMWO_RST_EVT;
    end else if (wr_enable) begin
      enable_q <= i_reg_wdata[`TMWO_EVT_W-1:0];
    end
  end

  // ****************************************
  // compare and period detection
  // ****************************************
  // period has priority: equal values are a software error and only the
  // period event is raised then, which keeps the counter reset reliable
  assign hit_period = i_count_tick && (i_count_value == period_value_q);
  // compare above period is never reached, so no compare event occurs
  assign hit_compare = i_count_tick && !hit_period
                       && (i_count_value == compare_value_q);

  assign o_compare_match = hit_compare;
  assign o_period_match = hit_period;

  // ****************************************
  // protection sources
  // ****************************************
  tmwo_noise_filter #(
    .SHORT_LEN(`TMWO_FILT_SHORT),
    .LONG_LEN(`TMWO_FILT_LONG),
    .CNT_W(4)
  ) u_pin_filter (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_raw(i_protect_input_pin),
    .i_long_sel(ctrl_q.protect_filter_length_sel),
    .o_level(pin_filtered)
  );

  assign adc_trip = ctrl_q.adc_protect_limit_sel ? i_adc_upper_out_of_range
                                                 : i_adc_lower_out_of_range;
  assign pin_trip = ctrl_q.pin_protect_level_sel ? !pin_filtered : pin_filtered;

  // forcing only happens for an armed source
  assign force_idle = (adc_trip && enable_q.adc_protect)
                      || (pin_trip && enable_q.pin_protect);

  // ****************************************
  // event flags
  // ****************************************
  always_comb begin
    set_evt.compare_event = hit_compare && enable_q.compare_event;
    set_evt.period_event = hit_period && enable_q.period_event;
    set_evt.adc_protect = adc_trip;
    set_evt.pin_protect = pin_trip;
    clr_evt = wr_flags ? tmwo_pkg::tmwo_evt_t'(i_reg_wdata[`TMWO_EVT_W-1:0])
                       : tmwo_pkg::tmwo_evt_t'(`TMWO_RST_EVT);
    // a set arriving with its clear is kept
    flags_d = (flags_q & ~clr_evt) | set_evt;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      flags_q <= `TMWO_RST_EVT;
    end else begin
      flags_q <= flags_d;
    end
  end

  // one shared request line; handler reads the flags for the cause
  assign o_irq = |(flags_q & enable_q);

  // ****************************************
  // waveform generator
  // ****************************************
  assign idle_level = ctrl_q.idle_level_sel ^ ctrl_q.polarity_invert;

  // the pre-polarity phase is tracked; polarity is applied at the output
  // so a polarity change mid-run flips the pin cleanly
  always_comb begin
    state_d = state_q;
    case (state_q)
      tmwo_pkg::TMWO_ST_IDLE: begin
        if (ctrl_q.wave_out_enable) begin
          state_d = ctrl_q.idle_level_sel ? tmwo_pkg::TMWO_ST_ON
                                          : tmwo_pkg::TMWO_ST_OFF;
        end
      end
      tmwo_pkg::TMWO_ST_OFF: begin
        if (hit_compare) begin
          state_d = tmwo_pkg::TMWO_ST_ON;
        end
      end
      tmwo_pkg::TMWO_ST_ON: begin
        if (hit_period) begin
          state_d = tmwo_pkg::TMWO_ST_OFF;
        end else if (hit_compare) begin
          state_d = tmwo_pkg::TMWO_ST_ON;
        end
      end
      default: begin
        state_d = tmwo_pkg::TMWO_ST_IDLE;
      end
    endcase
    if (hit_period && state_q == tmwo_pkg::TMWO_ST_OFF) begin
      state_d = tmwo_pkg::TMWO_ST_OFF;
    end
    if (!ctrl_q.wave_out_enable || force_idle) begin
      state_d = tmwo_pkg::TMWO_ST_IDLE;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_q <= tmwo_pkg::TMWO_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // output pins
  // ****************************************
  // registered from the next state, so a stop or trip reaches the pin
  // on the very edge that detects it
  always_comb begin
    case (state_d)
      tmwo_pkg::TMWO_ST_ON: begin
        wave_d = 1'b1 ^ ctrl_q.polarity_invert;
      end
      tmwo_pkg::TMWO_ST_OFF: begin
        wave_d = ctrl_q.polarity_invert;
      end
      default: begin
        wave_d = idle_level;
      end
    endcase
    if (force_idle) begin
      wave_d = ctrl_q.idle_level_sel ^ ctrl_q.polarity_invert;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wave_q <= 1'b0;
    end else begin
      wave_q <= wave_d;
    end
  end

  assign o_wave_out = wave_q;
  assign o_wave_out_n = !wave_q;

  // ****************************************
  // register read port
  // ****************************************
  // unmapped addresses read zero; data stands one cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdata_q <= `TMWO_RST_VALUE;
    end else if (i_reg_read) begin
      if (i_reg_addr == `TMWO_OFS_PERIOD) begin
        rdata_q <= `TMWO_DATA_W'(period_value_q);
      end else if (i_reg_addr == `TMWO_OFS_COMPARE) begin
        rdata_q <= `TMWO_DATA_W'(compare_value_q);
      end else if (i_reg_addr == `TMWO_OFS_CTRL) begin
        rdata_q <= {9'h000, ctrl_q};
      end else if (i_reg_addr == `TMWO_OFS_EVT_EN) begin
        rdata_q <= {12'h000, enable_q};
      end else if (i_reg_addr == `TMWO_OFS_EVT_FLAGS) begin
        rdata_q <= {12'h000, flags_q};
      end else begin
        rdata_q <= `TMWO_RST_VALUE;
      end
    end else begin
      rdata_q <= `TMWO_RST_VALUE;
    end
  end

  assign o_reg_rdata = rdata_q;

endmodule
`default_nettype wire

// ---- verification/tmwo_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "tmwo_defs.svh"

module tmwo_checker #(
  parameter int VALUE_W = 16
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [`TMWO_ADDR_W-1:0] i_reg_addr,
  input wire logic [`TMWO_DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic [`TMWO_DATA_W-1:0] o_reg_rdata,
  input wire logic [VALUE_W-1:0] i_count_value,
  input wire logic i_count_tick,
  input wire logic o_compare_match,
  input wire logic o_period_match,
  input wire logic i_adc_upper_out_of_range,
  input wire logic i_adc_lower_out_of_range,
  input wire logic i_protect_input_pin,
  input wire logic o_wave_out,
  input wire logic o_wave_out_n,
  input wire logic o_irq
);
  // ********
  // shadow of software writes
  // ********
  // a trip clears the enable bit inside the design only; tests rewrite control after one
  logic [VALUE_W-1:0] cmp_q, prd_q;
  logic [6:0] ctl_q;
  logic [3:0] en_q;
  logic trip;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cmp_q <= '0;
      prd_q <= '0;
      ctl_q <= 7'h00;
      en_q <= 4'h0;
    end else if (i_reg_write) begin
      case (i_reg_addr)
        `TMWO_OFS_COMPARE: cmp_q <= i_reg_wdata[VALUE_W-1:0];
        `TMWO_OFS_PERIOD: prd_q <= i_reg_wdata[VALUE_W-1:0];
        `TMWO_OFS_CTRL: ctl_q <= i_reg_wdata[6:0];
        `TMWO_OFS_EVT_EN: en_q <= i_reg_wdata[3:0];
        default: ;
      endcase
    end
  end
  assign trip = en_q[1] && (ctl_q[6] ? i_adc_upper_out_of_range : i_adc_lower_out_of_range);

  // ********
  // properties
  // ********
  property p_cmp;
    o_compare_match == (i_count_tick && i_count_value == cmp_q && cmp_q != prd_q);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare match wrong");
  property p_prd;
    o_period_match == (i_count_tick && i_count_value == prd_q);
  endproperty
  a_prd: assert property (p_prd) else $error("period match wrong");
  property p_compl;
    o_wave_out_n != o_wave_out;
  endproperty
  a_compl: assert property (p_compl) else $error("outputs not complementary");
  property p_cmp_out;
    o_compare_match && ctl_q[2] |=> o_wave_out != ctl_q[0];
  endproperty
  a_cmp_out: assert property (p_cmp_out) else $error("no active level after compare");
  property p_prd_out;
    o_period_match && ctl_q[2] |=> o_wave_out == ctl_q[0];
  endproperty
  a_prd_out: assert property (p_prd_out) else $error("no off level after period");
  property p_stop;
    i_reg_write && i_reg_addr == `TMWO_OFS_CTRL && !i_reg_wdata[2]
      |-> ##2 o_wave_out == (ctl_q[1] ^ ctl_q[0]);
  endproperty
  a_stop: assert property (p_stop) else $error("idle level wrong after stop");
  property p_adc;
    trip |-> ##[1:2] (o_irq && o_wave_out == (ctl_q[1] ^ ctl_q[0]));
  endproperty
  a_adc: assert property (p_adc) else $error("adc trip not taken");
  property p_irq_hold;
    $fell(o_irq) |-> $past(i_reg_write)
      && ($past(i_reg_addr) == `TMWO_OFS_EVT_FLAGS || $past(i_reg_addr) == `TMWO_OFS_EVT_EN);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("request dropped unasked");
endmodule

bind tmwo_top tmwo_checker #(.VALUE_W(VALUE_W)) u_chk (
  .i_core_clk, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_write, .i_reg_read, .o_reg_rdata,
  .i_count_value, .i_count_tick, .o_compare_match, .o_period_match,
  .i_adc_upper_out_of_range, .i_adc_lower_out_of_range, .i_protect_input_pin,
  .o_wave_out, .o_wave_out_n, .o_irq
);
`default_nettype wire

// ---- verification/tmwo_far_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// ********
// protection sensor and converter channel 0 range monitor
// ********
module tmwo_far_model (
  input wire logic i_core_clk,
  input wire logic i_pin_safe,
  input wire logic [3:0] i_pin_len,
  input wire logic i_pin_go,
  input wire logic i_adc_up_go,
  input wire logic i_adc_lo_go,
  output logic o_pin,
  output logic o_adc_up = 1'b0,
  output logic o_adc_lo = 1'b0
);
  logic [3:0] left_q = 4'h0;
  // pin rests at the safe level; a fault holds the other level for whole clocks
  always_ff @(posedge i_core_clk) begin
    left_q <= i_pin_go ? i_pin_len : left_q - 4'(left_q != 4'h0);
    o_adc_up <= i_adc_up_go;
    o_adc_lo <= i_adc_lo_go;
  end
  assign o_pin = (left_q != 4'h0) ? !i_pin_safe : i_pin_safe;
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "tmwo_defs.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %0h got %0h", n, e, g); end end

module tb;
  localparam logic [15:0] PRD = `TMWO_OFS_PERIOD;
  localparam logic [15:0] CMP = `TMWO_OFS_COMPARE;
  localparam logic [15:0] CTL = `TMWO_OFS_CTRL;
  localparam logic [15:0] IEN = `TMWO_OFS_EVT_EN;
  localparam logic [15:0] IFL = `TMWO_OFS_EVT_FLAGS;
  localparam logic [15:0] REGS [5] = '{PRD, CMP, CTL, IEN, IFL};
  logic i_core_clk, i_rst, i_reg_write, i_reg_read, i_count_tick, i_protect_input_pin;
  logic i_adc_upper_out_of_range, i_adc_lower_out_of_range;
  logic [15:0] i_reg_addr, i_reg_wdata, i_count_value, o_reg_rdata, rv;
  logic o_period_match, o_wave_out, o_wave_out_n, o_irq, run, safe, pgo, ugo, lgo;
  logic [3:0] plen;
  int failures, compares;

  tmwo_top dut (
    .i_core_clk, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_write, .i_reg_read, .o_reg_rdata,
    .i_count_value, .i_count_tick, .o_compare_match(), .o_period_match,
    .i_adc_upper_out_of_range, .i_adc_lower_out_of_range, .i_protect_input_pin,
    .o_wave_out, .o_wave_out_n, .o_irq
  );
  tmwo_far_model far (
    .i_core_clk, .i_pin_safe(safe), .i_pin_len(plen), .i_pin_go(pgo), .i_adc_up_go(ugo),
    .i_adc_lo_go(lgo), .o_pin(i_protect_input_pin), .o_adc_up(i_adc_upper_out_of_range),
    .o_adc_lo(i_adc_lower_out_of_range)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  // ********
  // up-counter, cleared by the period match
  // ********
  always @(posedge i_core_clk) begin
    if (i_rst || !run) begin
      i_count_tick <= 1'b0;
      i_count_value <= 16'h0;
    end else begin
      i_count_tick <= 1'b1;
      if (i_count_tick) begin
        i_count_value <= o_period_match ? 16'h0 : i_count_value + 16'h1;
      end
    end
  end

  // ********
  // bus and stimulus helpers
  // ********
  task cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_reg_write <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_core_clk);
    i_reg_write <= 1'b0;
  endtask
  task rd(input logic [15:0] a);
    @(posedge i_core_clk);
    i_reg_read <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_core_clk);
    i_reg_read <= 1'b0;
    #1;
    rv = o_reg_rdata;
  endtask
  task pulse(input logic [3:0] n);
    @(posedge i_core_clk);
    plen <= n;
    pgo <= 1'b1;
    @(posedge i_core_clk);
    pgo <= 1'b0;
    cyc(30);
  endtask
  task adc(input logic up);
    @(posedge i_core_clk);
    ugo <= up;
    lgo <= !up;
    @(posedge i_core_clk);
    ugo <= 1'b0;
    lgo <= 1'b0;
    cyc(3);
  endtask
  task spin(input int n);
    @(posedge i_core_clk);
    run <= 1'b1;
    repeat (n) @(posedge i_core_clk);
    run <= 1'b0;
    cyc(2);
  endtask

  // ********
  // scenarios
  // ********
  task t_regs;
    `CHK("rst_out", 1'b0, o_wave_out)
    foreach (REGS[i]) begin
      rd(REGS[i]);
      `CHK("rst_reg", 16'h0, rv)
    end
    wr(16'h5200, 16'hffff);
    rd(16'h5200);
    `CHK("unmapped", 16'h0, rv)
    // pin level select left at 0: the resting pin would otherwise trip and re-set its flag
    wr(CTL, 16'hffdb);
    rd(CTL);
    `CHK("ctl_bits", 16'h0053, rv)
    wr(IFL, 16'hffff);
    rd(IFL);
    `CHK("w1c", 16'h0, rv)
  endtask
  task t_idle;
    for (int i = 0; i < 4; i++) begin
      wr(CTL, 16'(i));
      cyc(3);
      `CHK("idle", 1'(i[0] ^ i[1]), o_wave_out)
      `CHK("idle_n", 1'(!(i[0] ^ i[1])), o_wave_out_n)
    end
  endtask
  task t_wave(input logic p, input logic [15:0] c, input logic [15:0] pr, input logic [3:0] en);
    logic [3:0] ef;
    ef = en & {c < pr, 3'b100};
    wr(PRD, pr);
    wr(CMP, c);
    wr(IFL, 16'hf);
    wr(IEN, {12'h0, en});
    wr(CTL, {13'h0, 2'b10, p});
    cyc(3);
    @(posedge i_core_clk);
    run <= 1'b1;
    repeat (14) begin
      @(posedge i_core_clk);
      #1;
      `CHK("wave", 1'(p ^ (i_count_value > c)), o_wave_out)
    end
    @(posedge i_core_clk);
    run <= 1'b0;
    cyc(2);
    rd(IFL);
    `CHK("flags", {12'h0, ef}, rv)
    `CHK("irq", |ef, o_irq)
    wr(IFL, 16'hf);
    rd(IFL);
    `CHK("cleared", 16'h0, rv)
    `CHK("irq_off", 1'b0, o_irq)
    wr(CTL, {15'h0, p});
    cyc(3);
    `CHK("stop", p, o_wave_out)
  endtask
  task t_adc(input logic lim, input logic en);
    wr(IEN, {14'h0, en, 1'b0});
    wr(PRD, 16'h7);
    wr(CMP, 16'h0);
    wr(CTL, {9'h0, lim, 6'h04});
    cyc(3);
    spin(4);
    `CHK("active", 1'b1, o_wave_out)
    adc(!lim);
    rd(IFL);
    `CHK("other_lim", 16'h0, rv)
    adc(lim);
    `CHK("trip", !en, o_wave_out)
    `CHK("trip_irq", en, o_irq)
    rd(IFL);
    `CHK("adc_flag", 16'h2, rv)
    rd(CTL);
    `CHK("ctl_after", {9'h0, lim, 3'h0, !en, 2'h0}, rv)
    wr(IFL, 16'hf);
    wr(CTL, 16'h0);
  endtask
  task t_pin(input logic f, input logic lv);
    wr(IEN, 16'h0);
    @(posedge i_core_clk);
    safe <= lv;
    wr(CTL, {10'h0, lv, f, 4'h4});
    cyc(20);
    wr(IFL, 16'hf);
    wr(IEN, 16'h1);
    pulse(f ? 4'd11 : 4'd5);
    rd(IFL);
    `CHK("short", 16'h0, rv)
    pulse(f ? 4'd12 : 4'd6);
    rd(IFL);
    `CHK("pin_flag", 16'h1, rv)
    `CHK("pin_irq", 1'b1, o_irq)
    rd(CTL);
    `CHK("pin_ctl", {10'h0, lv, f, 4'h0}, rv)
    wr(IFL, 16'hf);
  endtask

  task print_verdict;
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    {i_rst, i_reg_write, i_reg_read, i_count_tick, run, safe, pgo, ugo, lgo} = 9'h100;
    {i_reg_addr, i_reg_wdata, i_count_value, plen} = '0;
    repeat (5) @(posedge i_core_clk);
    i_rst <= 1'b0;
    t_regs;
    t_idle;
    t_wave(1'b0, 16'h1, 16'h3, 4'hc);
    t_wave(1'b1, 16'h2, 16'h5, 4'hc);
    t_wave(1'b0, 16'h0, 16'h1, 4'h4);
    t_wave(1'b1, 16'h7, 16'h3, 4'hc);
    t_wave(1'b0, 16'h1, 16'h4, 4'h0);
    t_adc(1'b0, 1'b1);
    t_adc(1'b1, 1'b1);
    t_adc(1'b0, 1'b0);
    for (int i = 0; i < 4; i++) t_pin(i[0], i[1]);
    print_verdict;
  end

  initial begin
    #2000000;
    failures++;
    print_verdict;
  end
endmodule
`default_nettype wire
